// >>> bench/result_capture.sv
// far-side model that captures the split result
`timescale 1ns/1ps
module result_capture
  import sar_pkg::*;
(
  input  wire logic [HALF_BITS-1:0] resultBus,     // six-bit result bus
  input  wire logic                 resultStrobe,  // result strobe
  output      logic [HALF_BITS-1:0] upperHalf,     // last upper half taken
  output      logic [HALF_BITS-1:0] lowerHalf      // last lower half taken
);
  // upper half taken on the strobe rising edge
  always @(posedge resultStrobe)
  begin
    upperHalf <= resultBus;
  end
  // lower half taken on the falling edge
  always @(negedge resultStrobe)
  begin
    lowerHalf <= resultBus;
  end
endmodule : result_capture

// >>> bench/sar_conv_ctrl_props.sv
// assertion checker watching the sequencer ports
`timescale 1ns/1ps
module sar_conv_ctrl_props
  import sar_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH  // buffer depth, as in the sequencer
)
(
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire logic                 enable,
  input wire logic                 start,
  input wire logic                 calEnable,
  input wire logic                 singleEnded,
  input wire logic                 compResult,
  input wire logic                 compFire,
  input wire logic                 shortInputs,
  input wire logic                 groundNeg,
  input wire logic                 sampleOn,
  input wire logic [RES_BITS-1:0]  dacCode,
  input wire logic [TRIM_W-1:0]    offsetTrim,
  input wire logic [HALF_BITS-1:0] resultBus,
  input wire logic                 resultStrobe,
  input wire logic [RES_BITS-1:0]  fifoData,
  input wire logic                 fifoValid,
  input wire logic                 fifoReady,
  input wire logic                 busy
);
  // ----------------------------------
  // sequencing, stopped by enable low
  // ----------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn || !enable);

  property p_take; $rose(busy) |-> $past(start); endproperty
  a_take: assert property (p_take) else $error("conversion began unrequested");
  property p_samp; $rose(sampleOn) |=> sampleOn ##1 !sampleOn [*8]; endproperty
  a_samp: assert property (p_samp) else $error("sampling not two cycles");
  property p_len; $rose(sampleOn) |-> ##15 busy ##1 (sampleOn || !busy); endproperty
  a_len: assert property (p_len) else $error("conversion not sixteen cycles");
  property p_dac; $fell(sampleOn) |-> dacCode == 12'h800; endproperty
  a_dac: assert property (p_dac) else $error("first trial not mid scale");
  property p_fire; $fell(sampleOn) |-> compFire [*8]; endproperty
  a_fire: assert property (p_fire) else $error("comparator not fired per step");
  property p_strb; $rose(resultStrobe) |-> resultStrobe [*8] ##1 !resultStrobe; endproperty
  a_strb: assert property (p_strb) else $error("strobe high phase wrong");
  property p_mode; $rose(busy) |-> groundNeg == $past(singleEnded); endproperty
  a_mode: assert property (p_mode) else $error("mode not latched at start");
  property p_short;
    shortInputs |-> calEnable && !sampleOn && $past(compFire || shortInputs);
  endproperty
  a_short: assert property (p_short) else $error("inputs shorted without cal");
  property p_calseq;
    $fell(compFire) && calEnable && busy && !sampleOn
      |-> shortInputs ##1 (shortInputs && compFire);
  endproperty
  a_calseq: assert property (p_calseq) else $error("cal compare not at end");
  property p_trim;
    $changed(offsetTrim) |-> $past(shortInputs)
      && 5'(offsetTrim - $past(offsetTrim)) inside {5'h01, 5'h1f};
  endproperty
  a_trim: assert property (p_trim) else $error("trim moved outside cal step");
  // enable low must idle the sequencer even though it masks the rest
  property p_off; disable iff (!resetn) !enable |=> !busy && !resultStrobe; endproperty
  a_off: assert property (p_off) else $error("active while disabled");

  c_b2b: cover property ($rose(sampleOn) && $past(busy));
  c_trim: cover property ($changed(offsetTrim));
  c_fall: cover property ($fell(resultStrobe));
endmodule : sar_conv_ctrl_props

// >>> bench/sar_conv_ctrl_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module sar_conv_ctrl_tb
  import sar_pkg::*;
;
  logic        clk, resetn, enable, start, calEnable, singleEnded, fifoReady;
  logic        compResult, compFire, shortInputs, groundNeg, sampleOn, resultStrobe;
  logic        fifoValid, busy, offSign;
  logic [11:0] dacCode, fifoData, vin;
  logic [4:0]  offsetTrim;
  logic [5:0]  resultBus, upperHalf, lowerHalf;
  int          nMismatch = 0;
  int          numChecks = 0;

  // ideal comparator; offSign stands for the offset seen when shorted
  assign compResult = shortInputs ? offSign : (dacCode <= vin);

  sar_conv_ctrl dut (.clk(clk), .resetn(resetn), .enable(enable), .start(start),
    .calEnable(calEnable), .singleEnded(singleEnded), .compResult(compResult),
    .compFire(compFire), .shortInputs(shortInputs), .groundNeg(groundNeg),
    .sampleOn(sampleOn), .dacCode(dacCode), .offsetTrim(offsetTrim),
    .resultBus(resultBus), .resultStrobe(resultStrobe), .fifoData(fifoData),
    .fifoValid(fifoValid), .fifoReady(fifoReady), .busy(busy));
  result_capture partner (.resultBus(resultBus), .resultStrobe(resultStrobe),
    .upperHalf(upperHalf), .lowerHalf(lowerHalf));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------
  // shared tasks
  // ----------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stopTest;
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stopTest

  // take one buffered word; the wait is bounded
  task automatic pop(input logic [11:0] exp);
    int n = 0;
    @(negedge clk);
    while (fifoValid !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check("fifoData", fifoData, exp);
    @(posedge clk) fifoReady <= 1'b1;
    @(posedge clk) fifoReady <= 1'b0;
  endtask : pop

  // ----------------
  // scenarios
  // ----------------
  task automatic t_one(input logic [11:0] v, input logic se);
    int nBusy = 0, nSamp = 0, nShort = 0, nMode = 0;
    @(posedge clk);
    vin <= v;
    singleEnded <= se;
    start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (24)
    begin
      @(negedge clk);
      nBusy += busy;
      nSamp += sampleOn;
      nShort += shortInputs;
      nMode += (busy && groundNeg === se);
    end
    check("busy cycles", nBusy, 16);
    check("sample cycles", nSamp, 2);
    check("short cycles", nShort, calEnable ? 2 : 0);
    check("mode cycles", nMode, 16);
    pop(se ? {v[11:1], 1'b0} : v);
  endtask : t_one

  task automatic t_cal;
    @(posedge clk);
    offSign <= 1'b1;
    calEnable <= 1'b1;
    t_one(12'h123, 1'b0);
    check("trim after cal", offsetTrim, 5'h0f);
    @(posedge clk) calEnable <= 1'b0;
    t_one(12'h123, 1'b0);
    check("trim held", offsetTrim, 5'h0f);
  endtask : t_cal

  task automatic t_stream;
    int nIdle = 0;
    @(posedge clk);
    vin <= 12'h3c9;
    start <= 1'b1;
    fifoReady <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (64)
    begin
      @(negedge clk);
      nIdle += !busy;
    end
    check("idle gaps", nIdle, 0);
    check("upper half", upperHalf, 6'h0f);
    check("lower half", lowerHalf, 6'h09);
    @(posedge clk) start <= 1'b0;
    repeat (24) @(posedge clk);
    fifoReady <= 1'b0;
  endtask : t_stream

  // abort mid-conversion; the lost word must not reach the buffer
  task automatic t_abort;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (5) @(posedge clk);
    enable <= 1'b0;
    start <= 1'b1;
    repeat (6) @(negedge clk);
    check("busy disabled", busy, 1'b0);
    @(posedge clk);
    enable <= 1'b1;
    start <= 1'b0;
    t_one(12'h5a5, 1'b0);
  endtask : t_abort

  task automatic t_full;
    @(posedge clk);
    vin <= 12'h0f0;
    start <= 1'b1;
    repeat (700) @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    check("busy when full", busy, 1'b0);
    repeat (32) pop(12'h0f0);
    repeat (4) @(negedge clk);
    check("fifo empty", fifoValid, 1'b0);
  endtask : t_full

  initial
  begin
    {resetn, enable, start, calEnable, singleEnded, fifoReady, offSign} = 7'h00;
    vin = 12'h000;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    enable <= 1'b1;
    @(negedge clk);
    check("trim reset", offsetTrim, 5'h10);
    check("busy reset", busy, 1'b0);
    t_one(12'h000, 1'b0);
    t_one(12'hfff, 1'b0);
    t_one(12'h7ff, 1'b1);
    t_one(12'ha5c, 1'b0);
    t_cal;
    t_stream;
    t_abort;
    t_full;
    stopTest;
  end

  // watchdog well beyond the expected run of about 1100 cycles
  initial
  begin
    repeat (6000) @(posedge clk);
    nMismatch++;
    stopTest;
  end
endmodule : sar_conv_ctrl_tb

bind sar_conv_ctrl sar_conv_ctrl_props #(.DEPTH(DEPTH)) props (.clk(clk), .resetn(resetn),
  .enable(enable), .start(start), .calEnable(calEnable), .singleEnded(singleEnded),
  .compResult(compResult), .compFire(compFire), .shortInputs(shortInputs),
  .groundNeg(groundNeg), .sampleOn(sampleOn), .dacCode(dacCode), .offsetTrim(offsetTrim),
  .resultBus(resultBus), .resultStrobe(resultStrobe), .fifoData(fifoData),
  .fifoValid(fifoValid), .fifoReady(fifoReady), .busy(busy));

// >>> hw/result_fifo.sv
// first-in first-out buffer for finished conversion results
`timescale 1ns/1ps
module result_fifo
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
)
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output      logic             inReady,
  output      logic [WIDTH-1:0] outData,
  output      logic             outValid,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];       // word storage
  logic [AW-1:0]    wrPtr_r, wrPtr_nxt; // write index
  logic [AW-1:0]    rdPtr_r, rdPtr_nxt; // read index
  logic [AW:0]      count_r, count_nxt; // words held in storage, head register excluded
  logic [WIDTH-1:0] outData_r, outData_nxt; // registered head word
  logic             outValid_r, outValid_nxt; // head register full
  logic             push;
  logic             pop;
  logic             load;

  // the head register counts as one of the DEPTH words, so the whole
  // buffer never holds more than DEPTH results
  assign inReady  = ((count_r + (AW+1)'(outValid_r)) != (AW+1)'(DEPTH));
  assign push     = inValid && inReady;
  // head register refills when empty or being taken
  assign load     = (count_r != '0) && (!outValid_r || outReady);
  assign pop      = load;
  assign outData  = outData_r;
  assign outValid = outValid_r;

  // next pointer and head values
  always_comb
  begin
    wrPtr_nxt    = push ? wrPtr_r + 1'b1 : wrPtr_r;
    rdPtr_nxt    = pop ? rdPtr_r + 1'b1 : rdPtr_r;
    count_nxt    = count_r + (AW+1)'(push) - (AW+1)'(pop);
    outData_nxt  = load ? mem[rdPtr_r] : outData_r;
    outValid_nxt = load ? 1'b1 : (outReady ? 1'b0 : outValid_r);
  end

  // register state
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wrPtr_r    <= '0;
      rdPtr_r    <= '0;
      count_r    <= '0;
      outData_r  <= '0;
      outValid_r <= 1'b0;
    end
    else
    begin
      wrPtr_r    <= wrPtr_nxt;
      rdPtr_r    <= rdPtr_nxt;
      count_r    <= count_nxt;
      outData_r  <= outData_nxt;
      outValid_r <= outValid_nxt;
    end
  end

  // memory write port, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wrPtr_r] <= inData;
    end
  end

endmodule : result_fifo

// >>> hw/sar_conv_ctrl.sv
// sequencer for a twelve-bit successive-approximation converter
`timescale 1ns/1ps
module sar_conv_ctrl
  import sar_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                enable,       // circuit enable, high runs
  input  wire logic                start,        // conversion request
  input  wire logic                calEnable,    // offset calibration enable
  input  wire logic                singleEnded,  // single-ended select
  input  wire logic                compResult,   // comparator answer, 1 = input above dac
  output      logic                compFire,     // comparator trigger, active high
  output      logic                shortInputs,  // short comparator inputs
  output      logic                groundNeg,    // tie negative input as reference
  output      logic                sampleOn,     // sampling switch closed
  output      logic [RES_BITS-1:0] dacCode,      // dac level under test
  output      logic [TRIM_W-1:0]   offsetTrim,   // applied offset correction
  output      logic [HALF_BITS-1:0] resultBus,   // six-bit split result
  output      logic                resultStrobe, // result strobe
  output      logic [RES_BITS-1:0] fifoData,     // buffered full result
  output      logic                fifoValid,    // buffered result present
  input  wire logic                fifoReady,    // buffered result taken
  output      logic                busy          // conversion under way
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  seq_state_t          state_r, state_nxt;     // sequence phase
  logic [CNT_W-1:0]    step_r, step_nxt;       // cycle within conversion
  logic [RES_BITS-1:0] sar_r, sar_nxt;         // trial and decided bits
  logic [RES_BITS-1:0] result_r, result_nxt;   // last finished result
  logic [HALF_BITS-1:0] bus_r, bus_nxt;        // output bus register
  logic                strobe_r, strobe_nxt;   // strobe register
  logic [TRIM_W-1:0]   trim_r, trim_nxt;       // offset trim
  logic                mode_r, mode_nxt;       // latched single-ended mode
  logic                fifoInReady;            // buffer can accept
  logic                done;                   // last step of a conversion
  logic                resolved;               // all bits decided, word goes to buffer
  logic [RES_BITS-1:0] finalCode;              // result as stored

  // bit under test for a given decision step (step 2 tests bit 11)
  function automatic logic [RES_BITS-1:0] trialBit(input logic [CNT_W-1:0] s);
    trialBit = RES_BITS'(1) << (RES_BITS - 1 - (int'(s) - SAMPLE_CYC));
  endfunction : trialBit

  // single-ended mode drops the lsb, which carries no information
  function automatic logic [RES_BITS-1:0] maskRes(input logic [RES_BITS-1:0] c,
                                                   input logic se);
    maskRes = se ? {c[RES_BITS-1:1], 1'b0} : c;
  endfunction : maskRes

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  // 2 sample + 12 decide + 2 tail = 16 cycles; the tail holds the
  // calibration compare, so length never depends on calEnable
  assign done      = (state_r != ST_IDLE) && (step_r == CNT_W'(CONV_CYC - 1));
  assign finalCode = maskRes(sar_r, mode_r);
  // the word is buffered one step before the end, so the restart test on
  // the last step already sees this word in the buffer and never starts
  // a conversion whose result would find no room
  assign resolved  = (state_r == ST_CAL) && (step_r == CNT_W'(SAMPLE_CYC + RES_BITS));

  // next sequence state
  always_comb
  begin
    state_nxt = state_r;
    step_nxt  = step_r;
    sar_nxt   = sar_r;
    mode_nxt  = mode_r;
    unique case (state_r)
      ST_IDLE:
      begin
        // stalls when the buffer is full, so no result is dropped
        if (start && fifoInReady)
        begin
          state_nxt = ST_SAMPLE;
          step_nxt  = '0;
          mode_nxt  = singleEnded;
        end
      end
      ST_SAMPLE:
      begin
        step_nxt = step_r + 1'b1;
        if (step_r == CNT_W'(SAMPLE_CYC - 1))
        begin
          state_nxt = ST_DECIDE;
          sar_nxt   = trialBit(CNT_W'(SAMPLE_CYC));
        end
      end
      ST_DECIDE:
      begin
        // keep or drop the bit under test, then try the next one
        step_nxt = step_r + 1'b1;
        sar_nxt  = compResult ? sar_r : (sar_r & ~trialBit(step_r));
        if (step_r == CNT_W'(SAMPLE_CYC + RES_BITS - 1))
        begin
          state_nxt = ST_CAL;
        end
        else
        begin
          sar_nxt = sar_nxt | trialBit(step_r + 1'b1);
        end
      end
      ST_CAL:
      begin
        step_nxt = step_r + 1'b1;
        if (done)
        begin
          // back to sampling at once if start is still high and the buffer has room
          if (start && fifoInReady)
          begin
            state_nxt = ST_SAMPLE;
            step_nxt  = '0;
            mode_nxt  = singleEnded;
          end
          else
          begin
            state_nxt = ST_IDLE;
          end
        end
      end
    endcase
    if (!enable)
    begin
      state_nxt = ST_IDLE;
      step_nxt  = '0;
      sar_nxt   = '0;
    end
  end

  // sequence registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      step_r  <= '0;
      sar_r   <= '0;
      mode_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      step_r  <= step_nxt;
      sar_r   <= sar_nxt;
      mode_r  <= mode_nxt;
    end
  end

  // ---------------------------------------------------------------
  // offset calibration
  // ---------------------------------------------------------------
  // one compare with shorted inputs on the last step nudges the trim;
  // saturates so a stuck comparator cannot wrap the correction
  always_comb
  begin
    trim_nxt = trim_r;
    if (calEnable && done)
    begin
      if (compResult && (trim_r != '0))
        trim_nxt = trim_r - 1'b1;
      else if (!compResult && (trim_r != '1))
        trim_nxt = trim_r + 1'b1;
    end
  end

  // trim register, kept across enable so calibration is not lost
  always_ff @(posedge clk)
  begin
    if (!resetn)
      trim_r <= TRIM_MID;
    else
      trim_r <= trim_nxt;
  end

  // ---------------------------------------------------------------
  // result output
  // ---------------------------------------------------------------
  // strobe rises with the upper half on the bus, falls with the lower
  // half; one full period per sixteen-cycle conversion
  always_comb
  begin
    result_nxt = done ? finalCode : result_r;
    bus_nxt    = bus_r;
    strobe_nxt = strobe_r;
    if (state_r != ST_IDLE)
    begin
      if (step_r == STROBE_HI_FROM - 1'b1)
      begin
        bus_nxt    = result_nxt[RES_BITS-1:HALF_BITS];
        strobe_nxt = 1'b0;
      end
      else if (step_r == STROBE_HI_FROM)
        strobe_nxt = 1'b1;
      else if (step_r == STROBE_LO_FROM - 1'b1)
        bus_nxt    = result_r[HALF_BITS-1:0];
      else if (step_r == STROBE_LO_FROM)
        strobe_nxt = 1'b0;
    end
    if (!enable)
      strobe_nxt = 1'b0;
  end

  // output registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      result_r <= '0;
      bus_r    <= '0;
      strobe_r <= 1'b0;
    end
    else
    begin
      result_r <= result_nxt;
      bus_r    <= bus_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  // ---------------------------------------------------------------
  // analog side controls
  // ---------------------------------------------------------------
  assign compFire     = (state_r == ST_DECIDE) || (state_r == ST_CAL && done && calEnable);
  assign shortInputs  = (state_r == ST_CAL) && calEnable;
  assign groundNeg    = mode_r;
  assign sampleOn     = (state_r == ST_SAMPLE);
  assign dacCode      = sar_r;
  assign offsetTrim   = trim_r;
  assign resultBus    = bus_r;
  assign resultStrobe = strobe_r;
  assign busy         = (state_r != ST_IDLE);

  // ---------------------------------------------------------------
  // result buffer
  // ---------------------------------------------------------------
  result_fifo
  #(
    .WIDTH (RES_BITS),
    .DEPTH (DEPTH)
  )
  u_fifo
  (
    .clk      (clk),
    .resetn   (resetn),
    .inData   (finalCode),
    .inValid  (resolved),
    .inReady  (fifoInReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoReady)
  );

endmodule : sar_conv_ctrl

// >>> pkg/sar_pkg.sv
// package of constants for the successive-approximation conversion sequencer
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package sar_pkg;

  localparam int RES_BITS     = 12;         // result width
  localparam int HALF_BITS    = 6;          // width of the output bus
  localparam int SAMPLE_CYC   = 2;          // sampling phase length
  localparam int CONV_CYC     = 16;         // whole conversion length
  localparam int CNT_W        = 4;          // sequence counter width
  localparam int TRIM_W       = 5;          // offset trim width
  localparam logic [4:0] TRIM_MID = 5'h10;  // trim reset value, mid scale
  localparam logic [3:0] STROBE_HI_FROM = 4'h0; // strobe driven high at the end of this step, so high from the next
  localparam logic [3:0] STROBE_LO_FROM = 4'h8; // strobe driven low at the end of this step, so low from the next
  localparam int FIFO_DEPTH   = 32;         // result buffer depth

  // phase of the sequence
  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_DECIDE = 2'b10,
    ST_CAL    = 2'b11
  } seq_state_t;

endpackage : sar_pkg
